// >>> rtl/mram_host_pkg.sv
package mram_host_pkg;

	// Bus geometry
	localparam int ADDR_W = 21;
	localparam int DATA_W = 16;
	localparam int LANE_W = 8;

	// Clock period and printed times, in ns
	localparam int CLK_NS        = 10;
	localparam int T_CYCLE_NS    = 35;
	localparam int T_CYCLE_AU_NS = 45;
	localparam int T_PULSE_NS    = 15;
	localparam int T_ADDR_EOW_NS = 20;
	localparam int T_ADDR_EOW_AU = 30;
	localparam int T_DATA_EOW_NS = 10;
	localparam int T_RECOV_NS    = 12;
	localparam int T_HIGH_NS     = 2;
	localparam int T_SKEW_NS     = 2;
	localparam int T_ACCESS_NS   = 35;
	localparam int T_ACCESS_AU   = 45;

	// Least times round up to whole cycles, never below one
	function automatic int min_cyc(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int CYC_PULSE  = min_cyc(T_PULSE_NS);
	localparam int CYC_ADDR   = min_cyc(T_ADDR_EOW_NS);
	localparam int CYC_ADDR_A = min_cyc(T_ADDR_EOW_AU);
	localparam int CYC_DATA   = min_cyc(T_DATA_EOW_NS);
	localparam int CYC_RECOV  = min_cyc(T_RECOV_NS);
	localparam int CYC_HIGH   = min_cyc(T_HIGH_NS);
	localparam int CYC_CYCLE  = min_cyc(T_CYCLE_NS);
	localparam int CYC_CYCL_A = min_cyc(T_CYCLE_AU_NS);
	localparam int CYC_ACC    = min_cyc(T_ACCESS_NS);
	localparam int CYC_ACC_A  = min_cyc(T_ACCESS_AU);

	localparam int CNT_W = 4;

	// Write termination styles
	typedef enum logic [1:0] {
		TERM_WE   = 2'h0,
		TERM_CE   = 2'h1,
		TERM_LANE = 2'h2
	} term_e;

	// Sequencer states, Gray along idle-setup-strobe-recover
	typedef enum logic [2:0] {
		ST_IDLE    = 3'h0,
		ST_SETUP   = 3'h1,
		ST_STROBE  = 3'h3,
		ST_RECOVER = 3'h2,
		ST_READ    = 3'h6
	} state_e;

endpackage

// >>> rtl/mram_sync2.sv
// Two-stage synchroniser for pin inputs
module mram_sync2 #(
	parameter int W = 16
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta;

	// First stage feeds only the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end

endmodule

// >>> rtl/mram_host.sv
// Functional notes
// - A deasserted write, chip or lane enable stays high at least 2 ns before changing.
// - Both lane enables, when used together, switch within 2 ns of each other.
// - Chip enable falling edges and write cycles are at least 35 ns apart, 45 ns automotive.
// - Write intervals count from the last stable address to the next address change.
// - Chip enable low 15 ns and address valid 20 ns (30 automotive) before end of write.
// - Data valid 10 ns before end of write; address held 12 ns after it.
// - A lane-terminated write holds the lane enable low 15 ns before end of write.
// - Write enable stays high for every read.
module mram_host
	import mram_host_pkg::*;
#(
	parameter bit AUTOMOTIVE = 1'b0
) (
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic                       req_valid,
	input  wire logic                       req_write,
	input  wire mram_host_pkg::term_e       req_term,
	input  wire logic [mram_host_pkg::ADDR_W-1:0] req_addr,
	input  wire logic [mram_host_pkg::DATA_W-1:0] req_wdata,
	input  wire logic [1:0]                 req_lanes,
	output logic                            req_ready,
	output logic                            rsp_valid,
	output logic [mram_host_pkg::DATA_W-1:0] rsp_rdata,
	output logic [mram_host_pkg::ADDR_W-1:0] mem_addr,
	output logic                            chip_en_n,
	output logic                            write_en_n,
	output logic                            out_en_n,
	output logic                            hi_lane_sel_n,
	output logic                            lo_lane_sel_n,
	output logic [mram_host_pkg::DATA_W-1:0] dq_out,
	output logic                            dq_oe,
	input  wire logic [mram_host_pkg::DATA_W-1:0] dq_in
);
	import mram_host_pkg::*;

	localparam int ADDR_CYC  = AUTOMOTIVE ? CYC_ADDR_A : CYC_ADDR;
	localparam int CYCLE_CYC = AUTOMOTIVE ? CYC_CYCL_A : CYC_CYCLE;
	localparam int ACC_CYC   = AUTOMOTIVE ? CYC_ACC_A : CYC_ACC;
	// Strobe must cover pulse, address-to-end and data-to-end windows
	localparam int STB_A     = (CYC_PULSE > ADDR_CYC) ? CYC_PULSE : ADDR_CYC;
	localparam int STB_CYC   = (STB_A > CYC_DATA) ? STB_A : CYC_DATA;
	// Recovery covers address hold and the enable high time
	localparam int REC_CYC   = (CYC_RECOV > CYC_HIGH) ? CYC_RECOV : CYC_HIGH;

	state_e             state;
	logic [CNT_W-1:0]   cnt;
	logic [CNT_W-1:0]   gap;
	logic               is_write;
	term_e              term;
	logic [1:0]         lanes;
	logic [DATA_W-1:0]  rd_sync;
	logic [DATA_W-1:0]  req_wdata_q;
	logic [CNT_W-1:0]   stb_last;

	// Late-falling terminators need one more strobe cycle to keep their own 15 ns low time
	assign stb_last = (term == TERM_WE) ? CNT_W'(STB_CYC - 1) : CNT_W'(STB_CYC);

	// Read data comes from pins, so it is synchronised first
	mram_sync2 #(
		.W (DATA_W)
	) u_rd_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.d     (dq_in),
		.q     (rd_sync)
	);

	// Sequencer; a new cycle waits for both recovery and the cycle-time gap
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state    <= ST_IDLE;
			cnt      <= '0;
			is_write <= 1'b0;
			term     <= TERM_WE;
			lanes    <= 2'h0;
			mem_addr <= '0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (req_valid && req_ready) begin
						is_write <= req_write;
						term     <= req_term;
						lanes    <= req_lanes;
						mem_addr <= req_addr;
						cnt      <= '0;
						state    <= req_write ? ST_SETUP : ST_READ;
					end
				end
				ST_SETUP: begin
					cnt   <= '0;
					state <= ST_STROBE;
				end
				ST_STROBE: begin
					if (cnt == stb_last) begin
						cnt   <= '0;
						state <= ST_RECOVER;
					end else begin
						cnt <= cnt + CNT_W'(1);
					end
				end
				ST_READ: begin
					if (cnt == CNT_W'(ACC_CYC)) begin
						cnt   <= '0;
						state <= ST_RECOVER;
					end else begin
						cnt <= cnt + CNT_W'(1);
					end
				end
				ST_RECOVER: begin
					// Address held through recovery
					if (cnt == CNT_W'(REC_CYC - 1)) begin
						state <= ST_IDLE;
					end else begin
						cnt <= cnt + CNT_W'(1);
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// Spacing of chip enable falling edges
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gap <= '0;
		end else if (state == ST_IDLE && req_valid && req_ready) begin
			gap <= CNT_W'(CYCLE_CYC - 1);
		end else if (gap != '0) begin
			gap <= gap - CNT_W'(1);
		end
	end

	// Ready registered so it is a flop output
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			req_ready <= 1'b0;
		end else begin
			req_ready <= (state == ST_IDLE) && !(req_valid && req_ready)
				&& (gap <= CNT_W'(1));
		end
	end

	// Pin strobes; the terminating signal goes high first, others stay low one more
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			chip_en_n     <= 1'b1;
			write_en_n    <= 1'b1;
			out_en_n      <= 1'b1;
			hi_lane_sel_n <= 1'b1;
			lo_lane_sel_n <= 1'b1;
			dq_out        <= '0;
			dq_oe         <= 1'b0;
		end else begin
			chip_en_n     <= 1'b1;
			write_en_n    <= 1'b1;
			out_en_n      <= 1'b1;
			hi_lane_sel_n <= 1'b1;
			lo_lane_sel_n <= 1'b1;
			dq_oe         <= 1'b0;
			if (state == ST_SETUP || state == ST_STROBE) begin
				// Write enable low from setup, never later than chip enable, so outputs never turn on
				write_en_n <= 1'b0;
				chip_en_n  <= !(state == ST_STROBE || term != TERM_CE);
				// Both lanes switch on the same edge, zero skew
				lo_lane_sel_n <= !lanes[0] || (state == ST_SETUP && term == TERM_LANE);
				hi_lane_sel_n <= !lanes[1] || (state == ST_SETUP && term == TERM_LANE);
				dq_out     <= req_wdata_q;
				dq_oe      <= 1'b1;
				if (state == ST_STROBE && cnt == stb_last) begin
					// Terminating edge: chosen signal rises, partners hold one more cycle
					unique case (term)
						TERM_WE:   write_en_n <= 1'b1;
						TERM_CE:   chip_en_n  <= 1'b1;
						TERM_LANE: begin
							lo_lane_sel_n <= 1'b1;
							hi_lane_sel_n <= 1'b1;
						end
						default:   write_en_n <= 1'b1;
					endcase
				end
			end else if (state == ST_READ) begin
				chip_en_n     <= 1'b0;
				out_en_n      <= 1'b0;
				write_en_n    <= 1'b1;
				lo_lane_sel_n <= !lanes[0];
				hi_lane_sel_n <= !lanes[1];
			end
		end
	end

	// Write data captured with the request
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			req_wdata_q <= '0;
		end else if (state == ST_IDLE && req_valid && req_ready) begin
			req_wdata_q <= req_wdata;
		end
	end

	// Read answer when the count reaches ACC_CYC; synchroniser lag counts inside that time
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rsp_valid <= 1'b0;
			rsp_rdata <= '0;
		end else begin
			rsp_valid <= (state == ST_READ) && (cnt == CNT_W'(ACC_CYC)) && !is_write;
			if (state == ST_READ && cnt == CNT_W'(ACC_CYC)) begin
				rsp_rdata <= rd_sync;
			end
		end
	end

endmodule

// >>> testbench/mram_host_checker.sv
module mram_host_checker
	import mram_host_pkg::*;
(
	input  wire logic                             clk,
	input  wire logic                             rst_n,
	input  wire logic [mram_host_pkg::ADDR_W-1:0] mem_addr,
	input  wire logic                             chip_en_n,
	input  wire logic                             write_en_n,
	input  wire logic                             out_en_n,
	input  wire logic                             hi_lane_sel_n,
	input  wire logic                             lo_lane_sel_n,
	input  wire logic [mram_host_pkg::DATA_W-1:0] dq_out,
	input  wire logic                             dq_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic ov_q;
	logic wend;

	// Overlap tracker; end of write is the edge the overlap closes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			ov_q <= 1'b0;
		else
			ov_q <= !chip_en_n && !write_en_n;
	end
	assign wend = ov_q && (chip_en_n || write_en_n);

	we_high_a: assert property ($rose(write_en_n) |=> write_en_n) else $error("we dip");
	ce_high_a: assert property ($rose(chip_en_n) |=> chip_en_n) else $error("ce dip");
	lane_skew_a: assert property (
		$fell(lo_lane_sel_n) && !hi_lane_sel_n |-> $fell(hi_lane_sel_n))
		else $error("lane skew");
	ce_gap_a: assert property ($fell(chip_en_n) |=> (!$fell(chip_en_n)) [*3])
		else $error("ce too close");
	ce_width_a: assert property (wend |-> $past(chip_en_n, 2) == 1'b0) else $error("ce short");
	addr_setup_a: assert property (wend |-> mem_addr == $past(mem_addr, 2))
		else $error("addr late");
	data_valid_a: assert property (
		wend |-> $past(dq_oe) && $past(dq_out) == $past(dq_out, 2))
		else $error("data late");
	addr_hold_a: assert property (wend |=> $stable(mem_addr)) else $error("addr hold");
	lane_width_a: assert property (
		$rose(lo_lane_sel_n) |-> $past(lo_lane_sel_n, 2) == 1'b0)
		else $error("lane short");
	read_we_a: assert property (!out_en_n |-> write_en_n) else $error("we low in read");
	cover property (wend);
	cover property ($fell(out_en_n));
	cover property ($fell(lo_lane_sel_n) && $fell(hi_lane_sel_n));
endmodule

bind mram_host mram_host_checker chk_u (.clk(clk), .rst_n(rst_n), .mem_addr(mem_addr),
	.chip_en_n(chip_en_n), .write_en_n(write_en_n), .out_en_n(out_en_n),
	.hi_lane_sel_n(hi_lane_sel_n), .lo_lane_sel_n(lo_lane_sel_n), .dq_out(dq_out), .dq_oe(dq_oe));

// >>> testbench/mram_model.sv
module mram_model
	import mram_host_pkg::*;
(
	input  wire logic                             clk,
	input  wire logic [mram_host_pkg::ADDR_W-1:0] mem_addr,
	input  wire logic                             chip_en_n,
	input  wire logic                             write_en_n,
	input  wire logic                             out_en_n,
	input  wire logic                             hi_lane_sel_n,
	input  wire logic                             lo_lane_sel_n,
	input  wire logic [mram_host_pkg::DATA_W-1:0] dq_out,
	input  wire logic                             dq_oe,
	output logic      [mram_host_pkg::DATA_W-1:0] dq_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
	logic [DATA_W-1:0] word;

	// Array changes only inside the enable overlap, lane by lane
	always @(posedge clk) begin
		if (!chip_en_n && !write_en_n && dq_oe) begin
			word = mem.exists(mem_addr) ? mem[mem_addr] : '0;
			if (!lo_lane_sel_n) word[7:0] = dq_out[7:0];
			if (!hi_lane_sel_n) word[15:8] = dq_out[15:8];
			mem[mem_addr] = word;
		end
	end

	// Drives only on reads; toggles otherwise so a stale word never passes
	initial dq_in = '0;
	always @(negedge clk) begin
		if (!chip_en_n && write_en_n && !out_en_n)
			dq_in <= mem.exists(mem_addr) ? mem[mem_addr] : '0;
		else
			dq_in <= ~dq_in;
	end
endmodule

// >>> testbench/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import mram_host_pkg::*;
	logic              clk, rst_n, req_valid, req_write, req_ready, rsp_valid, dq_oe;
	logic              chip_en_n, write_en_n, out_en_n, hi_lane_sel_n, lo_lane_sel_n;
	term_e             req_term;
	logic [ADDR_W-1:0] req_addr, mem_addr;
	logic [DATA_W-1:0] req_wdata, rsp_rdata, dq_out, dq_in;
	logic [1:0]        req_lanes;
	logic [DATA_W-1:0] ref_mem [logic [ADDR_W-1:0]];
	int                n_fail, checked, cyc;

	mram_host dut_u (.clk, .rst_n, .req_valid, .req_write, .req_term, .req_addr, .req_wdata,
		.req_lanes, .req_ready, .rsp_valid, .rsp_rdata, .mem_addr, .chip_en_n, .write_en_n,
		.out_en_n, .hi_lane_sel_n, .lo_lane_sel_n, .dq_out, .dq_oe, .dq_in);
	mram_model mem_u (.clk, .mem_addr, .chip_en_n, .write_en_n, .out_en_n, .hi_lane_sel_n,
		.lo_lane_sel_n, .dq_out, .dq_oe, .dq_in);

	// Expected word: only selected lanes take new data
	function automatic logic [15:0] merged(input logic [15:0] old, nw, input logic [1:0] ln);
		return {ln[1] ? nw[15:8] : old[15:8], ln[0] ? nw[7:0] : old[7:0]};
	endfunction

	task automatic check(input string what, input logic [15:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Request held until taken; a read is compared with the reference word
	task automatic access(input logic w, input term_e t, input logic [ADDR_W-1:0] a,
		input logic [15:0] d, input logic [1:0] l);
		logic [15:0] old;
		old = ref_mem.exists(a) ? ref_mem[a] : '0;
		@(negedge clk);
		req_valid = 1'b1;
		req_write = w;
		req_term = t;
		req_addr = a;
		req_wdata = d;
		req_lanes = l;
		@(posedge clk);
		while (!req_ready) @(posedge clk);
		@(negedge clk);
		req_valid = 1'b0;
		if (w)
			ref_mem[a] = merged(old, d, l);
		else begin
			while (!rsp_valid) @(negedge clk);
			check("rdata", rsp_rdata, old);
		end
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Hang guard well beyond the expected run length
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			give_verdict();
		end
	end

	initial begin
		{rst_n, req_valid, req_write, req_addr, req_wdata, req_lanes} = '0;
		req_term = TERM_WE;
		void'($urandom(50));
		repeat (8) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		// Each termination at the top address, both lanes then one lane
		for (int t = 0; t < 3; t++) begin
			access(1'b1, term_e'(t), 21'h1fffff, 16'ha5c3 + 16'(t), 2'h3);
			access(1'b0, TERM_WE, 21'h1fffff, 16'h0, 2'h3);
			access(1'b1, term_e'(t), 21'h1fffff, 16'h0f0f, 2'h1 << t[0]);
			access(1'b0, TERM_WE, 21'h1fffff, 16'h0, 2'h3);
		end
		// No lane selected writes nothing
		access(1'b1, TERM_CE, 21'h0, 16'hffff, 2'h0);
		access(1'b0, TERM_WE, 21'h0, 16'h0, 2'h3);
		// Random traffic on a few addresses, back to back
		repeat (60) access(1'($urandom), term_e'($urandom_range(2)), 21'($urandom_range(7)),
			16'($urandom), 2'($urandom));
		give_verdict();
	end
endmodule
